// ### sfr_defs.svh
// Timing counts and encodings for the sample FIFO readout block.
// Assumes ref_clk is the master clock; times are counted in master clock periods.
// Behaviour
// - Ready indication on the data output stays high four cycles per internal FIFO write.
// - At least four quiet cycles after a read ends before ready rises again.
// - FIFO is empty within eight cycles of sync falling or a clear request.
// - Read starts at chip-select fall (four-wire) or first clock fall (three-wire).
// - Read ends at chip-select rise (four-wire) or last clock rise (three-wire).
// - FIFO interrupt timing applies when interrupt routing selects the pin, code zero.
// - Bits shifted per read equal the selected size: 8, 16 or 24.
// - Link uses clock idle high, data driven on falls, sampled on rises.
// - Three-wire mode by default; four_wire_select high frames reads by chip select.
// - With the FIFO enabled the interrupt pin may act as FIFO interrupt.
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

`define SFR_MCLK_HZ        25000000
`define SFR_REF_HZ         25000000
// Times in master clock periods, or tenths of one where noted
`define SFR_T_BSY_MCLK     4
`define SFR_T_QUIET2_MCLK  4
`define SFR_T_CLR_MCLK     8
`define SFR_T_SYNC_PW_MCLK 4
`define SFR_T_INT_RD_DMCLK 15
// Least times round up, longest times round down
`define SFR_BSY_CYC     ((`SFR_T_BSY_MCLK * `SFR_REF_HZ + `SFR_MCLK_HZ - 1) / `SFR_MCLK_HZ)
`define SFR_QUIET_CYC   ((`SFR_T_QUIET2_MCLK * `SFR_REF_HZ + `SFR_MCLK_HZ - 1) / `SFR_MCLK_HZ)
`define SFR_CLR_CYC     ((`SFR_T_CLR_MCLK * `SFR_REF_HZ) / `SFR_MCLK_HZ)
`define SFR_SYNC_PW_CYC ((`SFR_T_SYNC_PW_MCLK * `SFR_REF_HZ + `SFR_MCLK_HZ - 1) / `SFR_MCLK_HZ)
`define SFR_INT_RD_CYC  ((`SFR_T_INT_RD_DMCLK * `SFR_REF_HZ + 10 * `SFR_MCLK_HZ - 1) / (10 * `SFR_MCLK_HZ))

`define SFR_INT_ROUTE_PIN 2'h0
`define SFR_LEN_SEL_8     2'h0
`define SFR_LEN_SEL_16    2'h1
`define SFR_LEN_SEL_24    2'h2
`define SFR_LEN_8         8
`define SFR_LEN_16        16
`define SFR_LEN_24        24
`define SFR_FIFO_DEPTH    8
`define SFR_WORD_W        24

`endif

// ### sfr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
// Assumes a single clock; en freezes all state.
`timescale 1ns/1ns
module sfr_fifo #(
	parameter int W  = 24,
	parameter int D  = 8,
	localparam int AW = (D > 1) ? $clog2(D) : 1,
	localparam int CW = $clog2(D + 1)
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          en,
	input  wire logic          flush,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data,
	output logic [CW-1:0]      count
);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != CW'(D)) & ~flush;
	assign out_valid = (cnt_q != '0) & ~flush;
	assign out_data  = mem_q[rp_q];
	assign count     = cnt_q;

	// ==========================================================
	// Pointers and fill count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (en) begin
			if (flush) begin
				wp_q  <= '0;
				rp_q  <= '0;
				cnt_q <= '0;
			end else begin
				if (push)
					wp_q <= nxt(wp_q);
				if (pop)
					rp_q <= nxt(rp_q);
				if (push && !pop)
					cnt_q <= cnt_q + CW'(1);
				else if (pop && !push)
					cnt_q <= cnt_q - CW'(1);
			end
		end
	end

	// Storage carries no reset; only the pointers and fill count say what is valid
	always_ff @(posedge clk) begin
		if (en && push)
			mem_q[wp_q] <= in_data;
	end

endmodule

// ### sfr_host.sv
// Host serial reader model for the sample FIFO readout block.
// Assumes ref_clk is the device master clock; sclk half period 15 ns.
`timescale 1ns/1ns
module sfr_host (
	input  wire logic        ref_clk,
	input  wire logic        four_wire,
	input  wire logic        dout_o,
	output logic             sclk,
	output logic             cs_n,
	output logic [23:0]      rd_word,
	output logic             rd_strobe
);
	int gap;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		rd_word = 24'h000000;
		rd_strobe = 1'b0;
		gap = 0;
	end
	// Clock stands high between frames
	task automatic read_frame(input int n);
		int k;
		k = 0;
		while (dout_o !== 1'b0 && k < 50) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (2) @(posedge ref_clk);
		#7;
		cs_n = 1'b0;
		#5;
		// Short frames must not carry bits of the previous word
		rd_word = 24'h000000;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			#15;
			// Sample before the rise to dodge the end-of-frame gating
			rd_word = {rd_word[22:0], dout_o};
			sclk = 1'b1;
			#15;
		end
		if (four_wire) cs_n = 1'b1;
		rd_strobe = 1'b1;
		#1;
		rd_strobe = 1'b0;
		gap = 0;
		while (dout_o !== 1'b1 && gap < 20) begin
			@(posedge ref_clk);
			gap++;
		end
	endtask
endmodule

// ### sfr_pkg.sv
// Types shared by the sample FIFO readout block.
// Assumes sfr_defs.svh supplies the numeric constants.
package sfr_pkg;

	typedef struct packed {
		logic       four_wire_select;
		logic       fifo_en;
		logic [1:0] int_route;
		logic [1:0] rd_len_sel;
		logic [3:0] watermark;
	} sfr_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY,
		ST_READ,
		ST_QUIET
	} sfr_state_t;

endpackage

// ### sfr_tb.sv
// Self-checking bench for the sample FIFO readout block.
// Assumes sfr_host drives the link; samples go in at the falling edge.
`include "sfr_defs.svh"
`timescale 1ns/1ns
module tb;
	import sfr_pkg::*;
	logic      ref_clk, reset, clk_en, fifo_clear_req, samp_valid, sync_n;
	logic      samp_ready, dout_o, dout_oe, int_o, sclk, cs_n, rd_strobe;
	logic [23:0] samp_data, rd_word, e;
	sfr_cfg_t  cfg;
	int        mismatches, cmp_count, cyc, n_len, acc;
	logic [23:0] exp_q[$];

	sfr_top i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .cfg(cfg),
		.fifo_clear_req(fifo_clear_req), .samp_valid(samp_valid), .samp_ready(samp_ready),
		.samp_data(samp_data), .sclk(sclk), .cs_n(cs_n), .sync_n(sync_n),
		.dout_o(dout_o), .dout_oe(dout_oe), .int_o(int_o));
	sfr_host i_host (.ref_clk(ref_clk), .four_wire(cfg.four_wire_select), .dout_o(dout_o),
		.sclk(sclk), .cs_n(cs_n), .rd_word(rd_word), .rd_strobe(rd_strobe));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic push(output bit ok);
		int k;
		logic [23:0] v;
		k = 0;
		v = $urandom;
		@(negedge ref_clk);
		samp_valid = 1'b1;
		samp_data = v;
		#1;
		while (samp_ready !== 1'b1 && k < 12) begin
			@(negedge ref_clk);
			#1;
			k++;
		end
		ok = (samp_ready === 1'b1);
		if (ok) exp_q.push_back(v);
		@(negedge ref_clk);
		samp_valid = 1'b0;
	endtask

	task automatic drain();
		while (exp_q.size() > 0) begin
			i_host.read_frame(n_len);
			if (exp_q.size() > 0) check(i_host.gap >= 4, 1);
			repeat ($urandom_range(0, 6)) @(posedge ref_clk);
		end
		@(negedge ref_clk);
		check(dout_oe, !cfg.four_wire_select);
	endtask

	// Each finished frame is matched against the oldest accepted sample
	always @(posedge rd_strobe) begin
		if (exp_q.size() == 0) check(32'h1, 32'h0);
		else begin
			e = exp_q.pop_front();
			check(rd_word, e & (24'hFFFFFF >> (24 - n_len)));
		end
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		bit ok;
		int k;
		{reset, clk_en, fifo_clear_req, samp_valid, sync_n} = 5'h19;
		samp_data = 24'h000000;
		cfg = '{four_wire_select: 1'b1, fifo_en: 1'b1, int_route: 2'h0,
			rd_len_sel: 2'h2, watermark: 4'h1};
		n_len = 24;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		check({dout_o, dout_oe, int_o, samp_ready}, 4'h1);
		void'($urandom(38));
		// Ready indication width for one write
		push(ok);
		k = 0;
		while (dout_o === 1'b1 && k < 20) begin
			@(negedge ref_clk);
			k++;
		end
		// Holding-word load one cycle after the take restarts the count
		check(k >= `SFR_BSY_CYC + 1, 1);
		check(int_o, 1'b1);
		// Every length in both wire modes
		for (int m = 1; m >= 0; m--) begin
			for (int l = 0; l < 3; l++) begin
				cfg.four_wire_select = m[0];
				cfg.rd_len_sel = l[1:0];
				n_len = (l == 0) ? 8 : (l == 1) ? 16 : 24;
				push(ok);
				push(ok);
				drain();
			end
		end
		// Fill until refused, then drain with a stalling host
		acc = 0;
		ok = 1;
		while (ok && acc < 20) begin
			push(ok);
			acc += ok;
		end
		check(acc, `SFR_FIFO_DEPTH + 1);
		drain();
		// Watermark on the pin versus data-available routing
		cfg.watermark = 4'h4;
		repeat (3) push(ok);
		repeat (3) @(negedge ref_clk);
		check(int_o, 1'b0);
		cfg.int_route = 2'h1;
		repeat (3) @(negedge ref_clk);
		check(int_o, 1'b1);
		cfg.int_route = 2'h0;
		push(ok);
		repeat (3) @(negedge ref_clk);
		check(int_o, 1'b1);
		cfg.watermark = 4'h1;
		// Clear through the sync pin
		sync_n = 1'b0;
		repeat (`SFR_SYNC_PW_CYC) @(negedge ref_clk);
		sync_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({int_o, samp_ready}, 2'h1);
		exp_q.delete();
		// Clear through the control write, then a stale word must not appear
		push(ok);
		push(ok);
		fifo_clear_req = 1'b1;
		@(negedge ref_clk);
		fifo_clear_req = 1'b0;
		repeat (7) @(negedge ref_clk);
		check(int_o, 1'b0);
		exp_q.delete();
		// Frozen clock enable: nothing taken, ready indication held
		clk_en = 1'b0;
		push(ok);
		check(ok, 1'b0);
		check(dout_o, 1'b0);
		clk_en = 1'b1;
		push(ok);
		drain();
		results();
	end
endmodule

// ### sfr_top.sv
// Sample FIFO readout: ready indication on the data pin, FIFO interrupt, clearing, serial read.
// Assumes samples arrive on ref_clk; sclk, cs_n and sync_n are pins from the host.
`include "sfr_defs.svh"
`timescale 1ns/1ns
module sfr_top #(
	parameter int W = `SFR_WORD_W,
	parameter int D = `SFR_FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire sfr_pkg::sfr_cfg_t cfg,
	input  wire logic             fifo_clear_req,
	input  wire logic             samp_valid,
	output logic                  samp_ready,
	input  wire logic [W-1:0]     samp_data,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             sync_n,
	output logic                  dout_o,
	output logic                  dout_oe,
	output logic                  int_o
);
	import sfr_pkg::*;

	localparam int CW      = $clog2(D + 1);
	localparam int NW      = $clog2(W + 1);
	localparam int CLR_CYC = `SFR_CLR_CYC;
	localparam logic [3:0] BSY_C   = 4'(`SFR_BSY_CYC);
	localparam logic [3:0] QUIET_C = 4'(`SFR_QUIET_CYC);

	function automatic logic [NW-1:0] len_bits(input logic [1:0] sel);
		case (sel)
			`SFR_LEN_SEL_8:  len_bits = NW'(`SFR_LEN_8);
			`SFR_LEN_SEL_16: len_bits = NW'(`SFR_LEN_16);
			default:         len_bits = NW'(`SFR_LEN_24);
		endcase
	endfunction

	function automatic logic [NW-1:0] nxt_mod(input logic [NW-1:0] c, input logic [NW-1:0] n);
		nxt_mod = (c == n - NW'(1)) ? '0 : c + NW'(1);
	endfunction

	// ==========================================================
	// Pin and link crossings: 0 cs_n, 1 sync_n, 2 start toggle, 3 done toggle
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic       start_tgl_q;
	logic       done_tgl_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s1_q <= 4'h3;
			s2_q <= 4'h3;
			s3_q <= 4'h3;
		end else if (clk_en) begin
			s1_q <= {done_tgl_q, start_tgl_q, sync_n, cs_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	wire cs_fall   = s3_q[0] & ~s2_q[0];
	wire cs_rise   = ~s3_q[0] & s2_q[0];
	wire sync_fall = s3_q[1] & ~s2_q[1];
	wire start_ev  = s3_q[2] ^ s2_q[2];
	wire done_ev   = s3_q[3] ^ s2_q[3];

	wire rd_start = cfg.four_wire_select ? cs_fall : start_ev;
	wire rd_end   = cfg.four_wire_select ? cs_rise : done_ev;
	wire clear    = sync_fall | fifo_clear_req;

	// ==========================================================
	// FIFO and holding word
	sfr_state_t    state_q;
	sfr_state_t    state_d;
	logic [3:0]    cnt_q;
	logic [3:0]    cnt_d;
	logic [W-1:0]  hold_q;
	logic          hold_valid_q;
	logic          busy_q;
	logic          oe_q;
	logic          int_q;
	logic          f_in_ready;
	logic          f_out_valid;
	logic [W-1:0]  f_out_data;
	logic [CW-1:0] f_count;

	// Reads and their quiet tail lock out sample takes and holding-word loads; a clear still flushes
	wire wr_ok     = ((state_q == ST_IDLE) || (state_q == ST_BUSY)) & ~rd_start & ~clear;
	wire hold_load = wr_ok & ~hold_valid_q & f_out_valid;
	wire samp_take = samp_valid & samp_ready;
	wire wr_ev     = samp_take | hold_load;

	// Frozen block must not report a sample as taken
	assign samp_ready = f_in_ready & wr_ok & clk_en;

	sfr_fifo #(
		.W (W),
		.D (D)
	) u_fifo (
		.clk       (ref_clk),
		.reset     (reset),
		.en        (clk_en),
		.flush     (clear),
		.in_valid  (samp_valid & wr_ok),
		.in_ready  (f_in_ready),
		.in_data   (samp_data),
		.out_valid (f_out_valid),
		.out_ready (hold_load),
		.out_data  (f_out_data),
		.count     (f_count)
	);

	// ==========================================================
	// Busy, read and quiet sequencing
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (rd_start)
					state_d = ST_READ;
				else if (wr_ev) begin
					state_d = ST_BUSY;
					cnt_d   = BSY_C;
				end
			end
			ST_BUSY: begin
				if (rd_start)
					state_d = ST_READ;
				else if (wr_ev)
					cnt_d = BSY_C;
				else if (cnt_q <= 4'h1) begin
					state_d = ST_IDLE;
					cnt_d   = 4'h0;
				end else
					cnt_d = cnt_q - 4'h1;
			end
			ST_READ: begin
				if (rd_end) begin
					state_d = ST_QUIET;
					cnt_d   = QUIET_C;
				end
			end
			ST_QUIET: begin
				if (rd_start)
					state_d = ST_READ;
				else if (cnt_q <= 4'h1) begin
					state_d = ST_IDLE;
					cnt_d   = 4'h0;
				end else
					cnt_d = cnt_q - 4'h1;
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = 4'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			busy_q  <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			busy_q  <= (state_d == ST_BUSY);
		end
	end

	// A word is consumed at read end; flush drops it too
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hold_q       <= '0;
			hold_valid_q <= 1'b0;
		end else if (clk_en) begin
			if (hold_load) begin
				hold_q       <= f_out_data;
				hold_valid_q <= 1'b1;
			end else if (clear || (state_q == ST_READ && rd_end))
				hold_valid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt pin and output enable
	wire [CW:0] lvl        = {1'b0, f_count} + (CW + 1)'(hold_valid_q);
	wire        route_pin  = (cfg.int_route == `SFR_INT_ROUTE_PIN);
	wire        fifo_mode  = cfg.fifo_en & route_pin;
	wire        wm_hit     = (lvl >= (CW + 1)'(cfg.watermark));
	wire        int_d      = fifo_mode ? wm_hit : hold_valid_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			int_q <= 1'b0;
			oe_q  <= 1'b0;
		end else if (clk_en) begin
			int_q <= int_d;
			oe_q  <= ~s2_q[0];
		end
	end

	// ==========================================================
	// Link domain on sclk; hold_q is steady while a read is open
	logic [NW-1:0] fcnt_q;
	logic [NW-1:0] rcnt_q;
	logic [W-1:0]  sh_q;
	logic          lk_dout_q;

	wire [NW-1:0] nbits  = len_bits(cfg.rd_len_sel);
	wire [W-1:0]  ld_w   = hold_q << (NW'(W) - nbits);
	wire          ld_msb = ld_w[W-1];
	wire          first  = (fcnt_q == '0);
	wire          lk_act = start_tgl_q ^ done_tgl_q;

	always_ff @(negedge sclk or posedge reset) begin
		if (reset) begin
			fcnt_q      <= '0;
			sh_q        <= '0;
			lk_dout_q   <= 1'b0;
			start_tgl_q <= 1'b0;
		end else begin
			fcnt_q <= nxt_mod(fcnt_q, nbits);
			if (first) begin
				lk_dout_q   <= ld_msb;
				sh_q        <= ld_w << 1;
				start_tgl_q <= ~start_tgl_q;
			end else begin
				lk_dout_q <= sh_q[W-1];
				sh_q      <= sh_q << 1;
			end
		end
	end

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			rcnt_q     <= '0;
			done_tgl_q <= 1'b0;
		end else begin
			rcnt_q <= nxt_mod(rcnt_q, nbits);
			if (rcnt_q == nbits - NW'(1))
				done_tgl_q <= ~done_tgl_q;
		end
	end

	// Data pin joins the ready indication and the shifted bits
	assign dout_o  = busy_q | (lk_act & lk_dout_q);
	assign dout_oe = oe_q;
	assign int_o   = int_q;

	// ==========================================================
	// Checks
	property p_bsy_min;
		@(posedge ref_clk) disable iff (reset)
		$rose(busy_q) |-> busy_q [*4];
	endproperty
	a_bsy_min: assert property (p_bsy_min) else $error("busy high too short");

	property p_quiet;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && state_q == ST_READ && rd_end) |=> !busy_q [*4];
	endproperty
	a_quiet: assert property (p_quiet) else $error("ready rose inside quiet time");

	property p_clr;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && clear) |-> ##[1:CLR_CYC] (f_count == '0 && !hold_valid_q);
	endproperty
	a_clr: assert property (p_clr) else $error("FIFO not cleared in time");

	property p_int_pin;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && fifo_mode && wm_hit) |=> int_o;
	endproperty
	a_int_pin: assert property (p_int_pin) else $error("watermark not on pin");

	property p_int_dr;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && !fifo_mode) |=> (int_o == $past(hold_valid_q));
	endproperty
	a_int_dr: assert property (p_int_dr) else $error("data ready role wrong");

	property p_start;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && rd_start && state_q != ST_READ) |=> (state_q == ST_READ && !busy_q);
	endproperty
	a_start: assert property (p_start) else $error("read start not taken");

	property p_end;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && state_q == ST_READ && rd_end) |=> (state_q == ST_QUIET && !hold_valid_q);
	endproperty
	a_end: assert property (p_end) else $error("read end not taken");

	property p_wire_mode;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && state_q == ST_IDLE && !cfg.four_wire_select && !start_ev) |=>
			state_q != ST_READ;
	endproperty
	a_wire_mode: assert property (p_wire_mode) else $error("framing ignores mode");

	property p_len;
		@(posedge sclk) disable iff (reset)
		(rcnt_q == nbits - NW'(1)) |=> (done_tgl_q != $past(done_tgl_q));
	endproperty
	a_len: assert property (p_len) else $error("read length mismatch");

	property p_mode3;
		@(negedge sclk) disable iff (reset)
		first |=> (lk_dout_q == $past(ld_msb));
	endproperty
	a_mode3: assert property (p_mode3) else $error("first bit not driven on fall");

	c_read:  cover property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_READ ##1 state_q == ST_QUIET);
	c_clear: cover property (@(posedge ref_clk) disable iff (reset)
		clear && f_count != '0);
	c_wm:    cover property (@(posedge ref_clk) disable iff (reset)
		fifo_mode && $rose(int_o));
	c_extend: cover property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_BUSY && wr_ev);

endmodule
